/* pkg/sipoc_regs.svh */
// sipoc_regs.svh: offsets, fields, resets and counts of the control bank.
// assumes byte address = 4 * register index.
//
// Operation
// R1: software writes all ones to the test register
// R2: threshold, 8 mV steps, 8 to 256 mV, resets to 15
// R3: polarity bit: zero negative, one positive, resets 0
// R4: sliced sync source select, resets to raw embedded sync
// R5: override clear selects channel automatically
// R6: under override, channel select picks channel 0 or 1
// R7: bandwidth bit zero low, one high, resets set
// R8: power-down select one: automatic from activity of both inputs
// R9: manual: bit forces sleep; normal needs bit clear, pin inactive
// R10: manual mode: sleep pin polarity zero active low, one active high
// R11: software sets pin polarity even if pin unused
// R12: fast switching: request keeps device awake, outputs float
// R13: control bit floats sliced sync output during power-down
// R14: output mode codes 100 RGB, 101 YCbCr 4:2:2, 110 DDR; resets to 100
// R15: DDR 4:4:4 mode presents RGB data on both output clock edges; code splits only red and green, blue pins carry secondary YCbCr
// R16: 4:2:2 mode uses twenty data pins instead of thirty
// R17: primary output enable one drives, zero floats
// R18: in 4:2:2 and DDR, blue is secondary, red and green are primary
// R19: secondary output carries DDR YCbCr, enable resets cleared
// R20: activity flag reads one only while its sync input toggles
// R21: software writes only the three defined output mode codes
`ifndef SIPOC_REGS_SVH
`define SIPOC_REGS_SVH

`define SIPOC_IDX_TEST      8'h1C
`define SIPOC_IDX_SLICE     8'h1D
`define SIPOC_IDX_INPWR     8'h1E
`define SIPOC_IDX_OUTFMT    8'h1F
`define SIPOC_IDX_ACTIVITY  8'h24
`define SIPOC_IDX_STATUS    8'h30

`define SIPOC_RST_TEST      8'h00
`define SIPOC_RST_SLICE     8'h78
`define SIPOC_RST_INPWR     8'h20
`define SIPOC_RST_OUTFMT    8'h90

`define SIPOC_SL_THR_MSB    7
`define SIPOC_SL_THR_LSB    3
`define SIPOC_SL_POL        2
`define SIPOC_SL_SEL_MSB    1
`define SIPOC_SL_SEL_LSB    0

`define SIPOC_IP_OVERRIDE   7
`define SIPOC_IP_CHSEL      6
`define SIPOC_IP_HIGHBW     5
`define SIPOC_IP_PDAUTO     4
`define SIPOC_IP_PDBIT      3
`define SIPOC_IP_PINPOL     2
`define SIPOC_IP_FAST       1
`define SIPOC_IP_SSHIZ      0

`define SIPOC_OF_MODE_MSB   7
`define SIPOC_OF_MODE_LSB   5
`define SIPOC_OF_PRIEN      4
`define SIPOC_OF_SECEN      3

`define SIPOC_MODE_444      3'h4
`define SIPOC_MODE_422      3'h5
`define SIPOC_MODE_DDR      3'h6

`define SIPOC_SEL_RAWGREEN  2'h0
`define SIPOC_SEL_RAWHSYNC  2'h1
`define SIPOC_SEL_REGEN     2'h2
`define SIPOC_SEL_FILTERED  2'h3

`define SIPOC_RESP_OK       2'h0
`define SIPOC_RESP_DECERR   2'h3

`define SIPOC_ACT_CYCLES    1000
`define SIPOC_ACT_W         10

`endif

/* pkg/sipoc_pkg.sv */
// sipoc_pkg: types shared by the register bank and its helper modules.
// assumes sipoc_regs.svh on the include path.
`include "sipoc_regs.svh"

package sipoc_pkg;

    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } sipoc_pixel_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } sipoc_bus_state_t;

    typedef struct packed {
        sipoc_bus_state_t bus;
        logic [7:0]       testReg;
        logic [7:0]       sliceReg;
        logic [7:0]       inPwrReg;
        logic [7:0]       outFmtReg;
        logic [31:0]      readData;
        logic [1:0]       response;
        logic             waitReq;
        logic             activeChannel;
        logic             pdRequest;
        logic             deviceSleep;
        logic             slicedSync;
        logic             slicedSyncOe;
        logic             highBandwidth;
        logic [4:0]       sliceThreshold;
    } sipoc_top_state_t;

    typedef struct packed {
        logic                   prev;
        logic [`SIPOC_ACT_W-1:0] count;
        logic                   active;
    } sipoc_act_state_t;

    typedef struct packed {
        sipoc_pixel_t rise;
        sipoc_pixel_t fall;
        logic         primaryOe;
        logic         blueOe;
        logic         crPhase;
    } sipoc_fmt_state_t;

endpackage

/* hw/sipoc_activity_det.sv */
// sipoc_activity_det: flags a sync input as active while it keeps toggling.
// assumes syncIn is synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "sipoc_regs.svh"

module sipoc_activity_det
(
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic syncIn,
    output logic      active
);

    sipoc_pkg::sipoc_act_state_t state;
    sipoc_pkg::sipoc_act_state_t next_state;

    always_comb
    begin
        next_state = state;
        next_state.prev = syncIn;
        if (syncIn != state.prev)
        begin
            // any edge restarts the window
            next_state.count = `SIPOC_ACT_W'(`SIPOC_ACT_CYCLES - 1);
            next_state.active = 1'b1;
        end
        else if (state.count != '0)
            next_state.count = state.count - `SIPOC_ACT_W'(1);
        else
            next_state.active = 1'b0; // see R20
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign active = state.active;

endmodule
`default_nettype wire

/* hw/sipoc_out_fmt.sv */
// sipoc_out_fmt: rise and fall pad words and pad enables for the chosen pixel.
// assumes pixIn holds Y on green, Pb on blue and Pr on red for YCbCr modes.
`timescale 1ns/100ps
`default_nettype none
`include "sipoc_regs.svh"

module sipoc_out_fmt
(
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic [2:0]            mode,
    input  wire logic                  primaryEn,
    input  wire logic                  secondaryEn,
    input  wire logic                  floatAll,
    input  wire sipoc_pkg::sipoc_pixel_t pixIn,
    output sipoc_pkg::sipoc_pixel_t    pixRise,
    output sipoc_pkg::sipoc_pixel_t    pixFall,
    output logic                       primaryOe,
    output logic                       blueOe
);

    sipoc_pkg::sipoc_fmt_state_t state;
    sipoc_pkg::sipoc_fmt_state_t next_state;

    always_comb
    begin
        logic [9:0] chroma;
        chroma = state.crPhase ? pixIn.red : pixIn.blue;
        next_state = state;
        next_state.rise = '0;
        next_state.fall = '0;
        next_state.primaryOe = primaryEn && !floatAll; // see R17
        next_state.blueOe = 1'b0;
        unique case (mode)
            `SIPOC_MODE_444:
            begin
                next_state.rise = pixIn;
                next_state.fall = pixIn;
                next_state.blueOe = primaryEn && !floatAll;
            end
            `SIPOC_MODE_422:
            begin
                // twenty primary pins: Y on green, alternating Cb/Cr on red
                next_state.rise.green = pixIn.green; // see R16
                next_state.rise.red = chroma;
                next_state.fall.green = pixIn.green;
                next_state.fall.red = chroma;
                next_state.crPhase = !state.crPhase;
            end
            `SIPOC_MODE_DDR:
            begin
                // upper halves on the rising edge, lower halves on the falling
                next_state.rise.red = {5'h00, pixIn.red[9:5]}; // see R15
                next_state.rise.green = {5'h00, pixIn.green[9:5]};
                next_state.fall.red = {5'h00, pixIn.red[4:0]};
                next_state.fall.green = {5'h00, pixIn.green[4:0]};
                next_state.crPhase = !state.crPhase;
            end
            default:
            begin
                // reserved codes present nothing and float the pads
                next_state.primaryOe = 1'b0;
                next_state.crPhase = 1'b0;
            end
        endcase
        if (mode == `SIPOC_MODE_422 || mode == `SIPOC_MODE_DDR)
        begin
            // blue pins become the secondary DDR YCbCr port
            next_state.rise.blue = pixIn.green; // see R18
            next_state.fall.blue = chroma; // see R19
            next_state.blueOe = secondaryEn && !floatAll; // see R19
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign pixRise = state.rise;
    assign pixFall = state.fall;
    assign primaryOe = state.primaryOe;
    assign blueOe = state.blueOe;

endmodule
`default_nettype wire

/* hw/sipoc_top.sv */
// sipoc_top: slicer output, channel, bandwidth, power and format control bank.
// assumes synchronous inputs; analog slicer, sync filter and pads sit outside.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "sipoc_regs.svh"

module sipoc_top
(
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic [9:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic [1:0]                   avs_response,
    output logic                         avs_waitrequest,
    input  wire logic [1:0]              horizontalSyncInput,
    input  wire logic [1:0]              greenEmbeddedSyncInput,
    input  wire logic                    regenHsync,
    input  wire logic                    filteredHsync,
    input  wire logic                    sleepPin,
    input  wire sipoc_pkg::sipoc_pixel_t pixChan0,
    input  wire sipoc_pkg::sipoc_pixel_t pixChan1,
    output logic [4:0]                   sliceThreshold,
    output logic                         highBandwidth,
    output logic                         activeChannel,
    output logic                         deviceSleep,
    output logic                         slicedSyncOutput,
    output logic                         slicedSyncOutputOe,
    output sipoc_pkg::sipoc_pixel_t      pixRise,
    output sipoc_pkg::sipoc_pixel_t      pixFall,
    output logic                         primaryOe,
    output logic                         blueOe
);

    ////////////////////////////////////////////////////////////////////////////////
    sipoc_pkg::sipoc_top_state_t state;
    sipoc_pkg::sipoc_top_state_t next_state;

    logic [3:0]              actFlags;
    logic [7:0]              regIndex;
    logic                    mapped;
    logic [7:0]              readByte;
    logic                    rawSync;
    logic                    manualReq;
    logic                    autoReq;
    sipoc_pkg::sipoc_pixel_t pixSel;

    ////////////////////////////////////////////////////////////////////////////////
    // activity detectors: [0] hsync0, [1] hsync1, [2] green sync0, [3] green sync1

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_act
            sipoc_activity_det u_act
            (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .syncIn   (gi < 2 ? horizontalSyncInput[gi % 2]
                                  : greenEmbeddedSyncInput[gi % 2]),
                .active   (actFlags[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    assign regIndex = avs_address[9:2];

    always_comb
    begin
        mapped = 1'b1;
        readByte = 8'h00;
        unique case (regIndex)
            `SIPOC_IDX_TEST:     readByte = state.testReg;
            `SIPOC_IDX_SLICE:    readByte = state.sliceReg;
            `SIPOC_IDX_INPWR:    readByte = state.inPwrReg;
            `SIPOC_IDX_OUTFMT:   readByte = {state.outFmtReg[7:3], 3'h0};
            `SIPOC_IDX_ACTIVITY: readByte = {actFlags[0], actFlags[1], 2'h0,
                                             actFlags[2], actFlags[3], 2'h0}; // see R20
            `SIPOC_IDX_STATUS:   readByte = {5'h00, state.activeChannel,
                                             state.pdRequest, state.deviceSleep};
            default:             mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        // pin counts as asserted when it matches the programmed polarity
        manualReq = state.inPwrReg[`SIPOC_IP_PDBIT]
                    || (sleepPin == state.inPwrReg[`SIPOC_IP_PINPOL]); // see R9 see R10
        autoReq = (actFlags == 4'h0); // see R8
        unique case (state.sliceReg[`SIPOC_SL_SEL_MSB:`SIPOC_SL_SEL_LSB]) // see R4
            `SIPOC_SEL_RAWGREEN: rawSync = greenEmbeddedSyncInput[state.activeChannel];
            `SIPOC_SEL_RAWHSYNC: rawSync = horizontalSyncInput[state.activeChannel];
            `SIPOC_SEL_REGEN:    rawSync = regenHsync;
            `SIPOC_SEL_FILTERED: rawSync = filteredHsync;
        endcase
        pixSel = state.activeChannel ? pixChan1 : pixChan0; // see R6
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_state = state;

        unique case (state.bus)
            sipoc_pkg::BUS_IDLE:
            begin
                next_state.waitReq = 1'b1;
                if (avs_read || avs_write)
                begin
                    next_state.bus = sipoc_pkg::BUS_ACK;
                    next_state.waitReq = 1'b0;
                    next_state.readData = avs_read ? {24'h000000, readByte} : 32'h00000000;
                    next_state.response = mapped ? `SIPOC_RESP_OK : `SIPOC_RESP_DECERR;
                end
            end
            sipoc_pkg::BUS_ACK:
            begin
                next_state.bus = sipoc_pkg::BUS_IDLE;
                next_state.waitReq = 1'b1;
                // the write lands on the edge where the master sees waitrequest low
                if (avs_write && avs_byteenable[0])
                begin
                    unique case (regIndex)
                        `SIPOC_IDX_TEST:   next_state.testReg = avs_writedata[7:0];
                        `SIPOC_IDX_SLICE:  next_state.sliceReg = avs_writedata[7:0];
                        `SIPOC_IDX_INPWR:  next_state.inPwrReg = avs_writedata[7:0];
                        `SIPOC_IDX_OUTFMT: next_state.outFmtReg = avs_writedata[7:0];
                        default:           next_state.testReg = state.testReg;
                    endcase
                end
            end
        endcase

        next_state.sliceThreshold =
            state.sliceReg[`SIPOC_SL_THR_MSB:`SIPOC_SL_THR_LSB]; // see R2
        next_state.highBandwidth = state.inPwrReg[`SIPOC_IP_HIGHBW]; // see R7

        // channel choice: hold the last active channel when both go quiet
        if (state.inPwrReg[`SIPOC_IP_OVERRIDE])
            next_state.activeChannel = state.inPwrReg[`SIPOC_IP_CHSEL]; // see R6
        else if (actFlags[0] || actFlags[2])
            next_state.activeChannel = 1'b0; // see R5
        else if (actFlags[1] || actFlags[3])
            next_state.activeChannel = 1'b1; // see R5

        next_state.pdRequest = state.inPwrReg[`SIPOC_IP_PDAUTO] ? autoReq : manualReq; // see R8
        // fast switching keeps the core awake; only the pads float
        next_state.deviceSleep = state.pdRequest
                                 && !state.inPwrReg[`SIPOC_IP_FAST]; // see R12

        // sliced sync pin: internal syncs are active high, negative inverts
        next_state.slicedSync = state.sliceReg[`SIPOC_SL_POL] ? rawSync : !rawSync; // see R3
        next_state.slicedSyncOe = !(state.pdRequest
                                    && state.inPwrReg[`SIPOC_IP_SSHIZ]); // see R13
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= '0;
            state.waitReq <= 1'b1;
            state.testReg <= `SIPOC_RST_TEST;
            state.sliceReg <= `SIPOC_RST_SLICE;
            state.inPwrReg <= `SIPOC_RST_INPWR;
            state.outFmtReg <= `SIPOC_RST_OUTFMT;
            state.sliceThreshold <= 5'(`SIPOC_RST_SLICE >> `SIPOC_SL_THR_LSB);
            state.highBandwidth <= 1'b1;
            state.slicedSyncOe <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    sipoc_out_fmt u_fmt
    (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .mode        (state.outFmtReg[`SIPOC_OF_MODE_MSB:`SIPOC_OF_MODE_LSB]), // see R14
        .primaryEn   (state.outFmtReg[`SIPOC_OF_PRIEN]),
        .secondaryEn (state.outFmtReg[`SIPOC_OF_SECEN]),
        .floatAll    (state.pdRequest), // see R12
        .pixIn       (pixSel),
        .pixRise     (pixRise),
        .pixFall     (pixFall),
        .primaryOe   (primaryOe),
        .blueOe      (blueOe)
    );

    ////////////////////////////////////////////////////////////////////////////////

    assign avs_readdata = state.readData;
    assign avs_response = state.response;
    assign avs_waitrequest = state.waitReq;
    assign sliceThreshold = state.sliceThreshold;
    assign highBandwidth = state.highBandwidth;
    assign activeChannel = state.activeChannel;
    assign deviceSleep = state.deviceSleep;
    assign slicedSyncOutput = state.slicedSync;
    assign slicedSyncOutputOe = state.slicedSyncOe;

endmodule
`default_nettype wire

/* tb/sipoc_top_asserts.sv */
// sipoc_top_asserts: bus timing and field effect checks for sipoc_top.
// assumes binding onto sipoc_top.
`timescale 1ns/100ps
`default_nettype none
module sipoc_top_asserts
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0]  avs_response,
    input wire logic        avs_waitrequest,
    input wire logic [4:0]  sliceThreshold,
    input wire logic        highBandwidth,
    input wire logic        activeChannel,
    input wire logic        deviceSleep,
    input wire logic        slicedSyncOutputOe,
    input wire logic        primaryOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic hit, wrD, wrE, wrF;
    // a write lands at the edge where waitrequest is seen low
    assign hit = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wrD = hit && avs_address[9:2] == 8'h1D;
    assign wrE = hit && avs_address[9:2] == 8'h1E;
    assign wrF = hit && avs_address[9:2] == 8'h1F;
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
    property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_rd_hi; (avs_read && !avs_waitrequest) |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    property p_thr; wrD |-> ##2 sliceThreshold == $past(avs_writedata[7:3], 2); endproperty
    property p_thr_hold; $changed(sliceThreshold) |-> $past(wrD, 2); endproperty
    property p_bw; wrE |-> ##2 highBandwidth == $past(avs_writedata[5], 2); endproperty
    property p_chan; wrE && avs_writedata[7] |-> ##2 activeChannel == $past(avs_writedata[6], 2);
    endproperty
    property p_manual; wrE && avs_writedata[4:3] == 2'h1 && !avs_writedata[1]
        |-> ##[1:3] deviceSleep; endproperty
    property p_fast; wrE && avs_writedata[4:3] == 2'h1 && avs_writedata[1]
        |-> ##3 (!deviceSleep && !primaryOe); endproperty
    property p_sso; wrE && avs_writedata[4:3] == 2'h1 && avs_writedata[0]
        |-> ##3 !slicedSyncOutputOe; endproperty
    property p_pri; wrF && !avs_writedata[4] |-> ##2 !primaryOe; endproperty
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_ack_one: assert property (p_ack_one)
        else $error("waitrequest low too long");
    a_rd_hi: assert property (p_rd_hi)
        else $error("read data upper bytes not zero");
    a_thr: assert property (p_thr)
        else $error("threshold not taken from write");
    a_thr_hold: assert property (p_thr_hold)
        else $error("threshold moved without write");
    a_bw: assert property (p_bw)
        else $error("bandwidth not taken from write");
    a_chan: assert property (p_chan)
        else $error("override channel not applied");
    a_manual: assert property (p_manual)
        else $error("manual power-down not entered");
    a_fast: assert property (p_fast)
        else $error("fast switching wrong");
    a_sso: assert property (p_sso)
        else $error("sliced sync output still driven");
    a_pri: assert property (p_pri)
        else $error("primary output still driven");
    c_slice: cover property (wrD);
    c_auto: cover property (wrE && avs_writedata[4]);
    c_decerr: cover property (avs_read && !avs_waitrequest && avs_response == 2'h3);
endmodule
`default_nettype wire

/* tb/sipoc_pixel_sink.sv */
// sipoc_pixel_sink: downstream pixel consumer, shows the level on the data pins.
// assumes primaryOe covers red and green, blueOe the blue pins.
`timescale 1ns/100ps
`default_nettype none
module sipoc_pixel_sink
(
    input  wire logic                    core_clk,
    input  wire sipoc_pkg::sipoc_pixel_t pixRise,
    input  wire logic                    primaryOe,
    input  wire logic                    blueOe,
    output var sipoc_pkg::sipoc_pixel_t  seen
);
    sipoc_pkg::sipoc_pixel_t last;
    // pins have no pull, so a floating pin shows the inverse of its last level
    always_comb
    begin
        seen = pixRise;
        if (!primaryOe)
        begin
            seen.red = ~last.red;
            seen.green = ~last.green;
        end
        if (!blueOe)
            seen.blue = ~last.blue;
    end
    always_ff @(posedge core_clk)
        last <= seen;
endmodule
`default_nettype wire

/* tb/tb.sv */
// tb: self-checking bench for sipoc_top with a pixel sink on the data pins.
// assumes byte address = 4 * register index.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                    core_clk, reset_n, avs_read, avs_write, regenHsync, filteredHsync;
    logic                    sleepPin, avs_waitrequest, highBandwidth, activeChannel, deviceSleep;
    logic                    slicedSyncOutput, slicedSyncOutputOe, primaryOe, blueOe, tg, src, req;
    logic [1:0]              avs_response, horizontalSyncInput, greenEmbeddedSyncInput, r;
    logic [3:0]              avs_byteenable;
    logic [4:0]              sliceThreshold, th;
    logic [7:0]              v;
    logic [7:0]              rg [28:31];
    logic [9:0]              avs_address;
    logic [31:0]             avs_writedata, avs_readdata, q;
    int                      errors, cmp_count;
    sipoc_pkg::sipoc_pixel_t pixChan0, pixChan1, pixRise, pixFall, seen, px;
    sipoc_top i_sipoc_top (.*);
    sipoc_pixel_sink i_sipoc_pixel_sink (.core_clk, .pixRise, .primaryOe, .blueOe, .seen);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
        int n = 0;
        @(posedge core_clk);
        avs_address <= {ix, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
            errors++;
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (w && ix >= 8'h1C && ix <= 8'h1F)
            rg[ix] = (ix == 8'h1F) ? (d & 8'hF8) : d;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        #3000000;
        errors++;
        print_verdict();
    end
    always @(posedge core_clk)
        if (tg)
            horizontalSyncInput[1] <= !horizontalSyncInput[1];
    initial
    begin
        {reset_n, avs_read, avs_write, regenHsync, filteredHsync, sleepPin, tg} = '0;
        {horizontalSyncInput, greenEmbeddedSyncInput, avs_address, avs_writedata} = '0;
        {pixChan0, pixChan1, errors, cmp_count} = '0;
        avs_byteenable = 4'hF;
        rg = '{8'h00, 8'h78, 8'h20, 8'h90};
        void'($urandom(32'hB991));
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        chk("rst", {sliceThreshold, highBandwidth}, 32'h1F);
        for (int i = 28; i < 32; i++)
        begin
            bus(1'b0, i[7:0], 8'h00);
            chk("reg_rst", q, {24'h000000, rg[i]});
        end
        bus(1'b1, 8'h1C, 8'hFF);
        bus(1'b1, 8'h1E, 8'hA4);
        bus(1'b0, 8'h00, 8'h00);
        chk("decerr", {r, q[29:0]}, 32'hC0000000);
        $display("test reset and bus done");
        for (int k = 0; k < 8; k++)
        begin
            th = 5'($urandom);
            {horizontalSyncInput, greenEmbeddedSyncInput, regenHsync, filteredHsync} <= 6'($urandom);
            bus(1'b1, 8'h1D, {th, 3'(k)});
            repeat (3) @(posedge core_clk);
            src = k[1] ? (k[0] ? filteredHsync : regenHsync)
                       : (k[0] ? horizontalSyncInput[0] : greenEmbeddedSyncInput[0]);
            chk("sso", slicedSyncOutput, k[2] ? src : !src);
            chk("thr", sliceThreshold, th);
        end
        $display("test slicer done");
        for (int c = 0; c < 2; c++)
        begin
            pixChan0 <= 30'($urandom);
            pixChan1 <= 30'($urandom);
            bus(1'b1, 8'h1E, c ? 8'hE4 : 8'hA4);
            repeat (3) @(posedge core_clk);
            px = c ? pixChan1 : pixChan0;
            chk("chan", activeChannel, c);
            chk("pix", seen, px);
            chk("pixf", pixFall, px);
        end
        for (int m = 5; m < 7; m++)
        begin
            bus(1'b1, 8'h1F, {3'(m), 5'h18});
            repeat (3) @(posedge core_clk);
            chk("oe", {primaryOe, blueOe}, 2'b11);
            if (m == 5)
                chk("y", {pixRise.green, pixRise.blue}, {2{px.green}});
            else
                chk("ddr", {pixRise.red, pixFall.red}, {5'h00, px.red[9:5], 5'h00, px.red[4:0]});
        end
        bus(1'b1, 8'h1F, 8'hB0);
        repeat (2) @(posedge core_clk);
        chk("sec_off", {primaryOe, blueOe}, 2'b10);
        bus(1'b1, 8'h1F, 8'h88);
        repeat (2) @(posedge core_clk);
        chk("pri_off", {primaryOe, blueOe}, 2'b00);
        bus(1'b1, 8'h1F, 8'h90);
        $display("test output format done");
        for (int k = 0; k < 32; k++)
        begin
            v = {4'hA, 4'(k)};
            sleepPin <= k[4];
            bus(1'b1, 8'h1E, v);
            repeat (4) @(posedge core_clk);
            req = v[3] | (k[4] == v[2]);
            chk("sleep", deviceSleep, req & !v[1]);
            chk("pd_oe", primaryOe, !req);
            chk("sso_oe", slicedSyncOutputOe, !(req & v[0]));
        end
        $display("test manual power done");
        {horizontalSyncInput, greenEmbeddedSyncInput} <= 4'h0;
        bus(1'b1, 8'h1E, 8'h34);
        repeat (1100) @(posedge core_clk);
        chk("idle_sleep", deviceSleep, 1'b1);
        bus(1'b0, 8'h24, 8'h00);
        chk("act_idle", q, 32'h0);
        tg <= 1'b1;
        repeat (20) @(posedge core_clk);
        bus(1'b0, 8'h24, 8'h00);
        chk("act_hs1", q, 32'h40);
        chk("wake", deviceSleep, 1'b0);
        chk("auto_chan", activeChannel, 1'b1);
        tg <= 1'b0;
        $display("test auto power done");
        print_verdict();
    end
endmodule
bind sipoc_top sipoc_top_asserts i_sipoc_top_asserts (.*);
`default_nettype wire
